// >>> src/nbs_pkg.sv
package nbs_pkg;
	// Byte offsets within the endpoint configuration space.
	localparam logic [11:0] OFS_BAR2 = 12'h018;
	localparam logic [11:0] OFS_BAR3 = 12'h01c;
	localparam logic [11:0] OFS_BAR4 = 12'h020;
	localparam logic [11:0] OFS_SETUP2 = 12'h08c;
	localparam logic [11:0] OFS_TBASE2 = 12'h090;
	localparam logic [11:0] OFS_SETUP3 = 12'h094;
	localparam logic [11:0] OFS_TBASE3 = 12'h098;
	localparam logic [11:0] OFS_SETUP4 = 12'h09c;

	// Setup register field positions.
	localparam int POS_SPACE = 0;
	localparam int POS_WIDTH = 1;
	localparam int POS_PREFETCHABLE_SELECT = 3;
	localparam int POS_SIZE = 4;
	localparam int POS_EN = 31;
	// Lowest address bit held by a base-address field.
	localparam int POS_BASE = 4;

	localparam logic [1:0] WIDTH_NARROW = 2'h0;
	localparam logic [1:0] WIDTH_WIDE = 2'h2;
	localparam logic SPACE_MEM = 1'h0;
	localparam logic [5:0] SIZE_MIN = 6'h04;
	localparam logic [5:0] SIZE_NARROW_MAX = 6'h20;
	localparam logic [5:0] SIZE_BAR4 = 6'h0c;
	localparam logic [31:0] TBASE_LO_MASK = 32'hffff_fff0;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;

	typedef struct packed {
		logic en;
		logic [5:0] size;
		logic prefetchable_select;
		logic [1:0] width;
		logic space;
	} nbs_setup_s;

	localparam nbs_setup_s RST_SETUP = '0;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} nbs_cfg_req_s;

	typedef struct packed {
		logic valid;
		logic io;
		logic [63:0] addr;
	} nbs_xreq_s;

	typedef struct packed {
		logic valid;
		logic [2:0] hit;
		logic [63:0] addr;
	} nbs_xrsp_s;
endpackage

// >>> src/nbs_xlat.sv
module nbs_xlat (
	input wire logic ok, // aperture enabled and sized
	input wire logic space, // aperture space kind, one for I/O
	input wire logic [63:0] base, // aperture base address
	input wire logic [63:0] tbase, // translated base address
	input wire logic [63:0] mask, // address bits compared and replaced
	input wire logic [63:0] addr, // incoming address
	input wire logic io, // incoming request is I/O
	output logic hit, // address falls in the aperture
	output logic [63:0] xaddr // translated address
);
	always_comb begin
		hit = ok && (io == space) && (((addr ^ base) & mask) == 64'h0);
		xaddr = (addr & ~mask) | (tbase & mask);
	end
endmodule

// >>> src/nbs_bar_regs.sv
module nbs_bar_regs (
	input wire logic clk, // 10 MHz clock
	input wire logic arst_n, // fundamental or hot reset
	input wire logic por_n, // power-on reset for kept settings
	input nbs_pkg::nbs_cfg_req_s cfg_req, // configuration access
	output logic cfg_rvalid, // read answer strobe
	output logic [31:0] cfg_rdata, // read answer data
	input nbs_pkg::nbs_xreq_s xreq, // address to translate
	output nbs_pkg::nbs_xrsp_s xrsp, // translation answer
	output logic [2:0] bar_live // BAR2..BAR4 decoding
);
	nbs_pkg::nbs_setup_s setup2_q;
	nbs_pkg::nbs_setup_s setup3_q;
	logic en4_q;
	nbs_pkg::nbs_setup_s setup4;
	logic [31:0] tbase2_q;
	logic [31:0] tbase3_q;
	logic [31:0] base2_q;
	logic [31:0] base3_q;
	logic [31:0] base4_q;
	logic wide2;
	logic [5:0] size2;
	logic [5:0] size3;
	logic [63:0] mask2;
	logic [63:0] mask3;
	logic [63:0] mask4;
	logic [31:0] wmask2;
	logic [31:0] wmask3;
	logic [31:0] wmask4;
	logic ok2;
	logic ok3;
	logic ok4;
	logic [31:0] rdata_d;
	logic [2:0] hit;
	logic [63:0] xaddr2;
	logic [63:0] xaddr3;
	logic [63:0] xaddr4;
	logic [63:0] base2_full;
	logic [63:0] tbase2_full;
	logic wr_setup2;
	logic wr_setup3;
	logic wr_setup4;
	logic wr_tbase2;
	logic wr_tbase3;
	logic wr_bar2;
	logic wr_bar3;
	logic wr_bar4;

	// Size that governs decoding, after the narrow-mode clamp.
	function automatic logic [5:0] eff_size(nbs_pkg::nbs_setup_s s, logic wide);
		logic [5:0] r;
		r = s.size;
		if (!wide && s.size > nbs_pkg::SIZE_NARROW_MAX) begin
			r = nbs_pkg::SIZE_NARROW_MAX;
		end
		return r;
	endfunction

	// One bit per address bit that a base-address field may hold.
	function automatic logic [63:0] addr_mask(logic [5:0] sz);
		logic [63:0] m;
		m = 64'h0;
		for (int i = nbs_pkg::POS_BASE; i < 64; i++) begin
			m[i] = (sz == 6'h0) ||
				(sz >= nbs_pkg::SIZE_MIN && 7'(i) >= {1'b0, sz});
		end
		return m;
	endfunction

	// A BAR decodes only when enabled and given a usable size.
	function automatic logic bar_ok(logic en, logic [5:0] sz);
		return en && !(sz != 6'h0 && sz < nbs_pkg::SIZE_MIN);
	endfunction

	// Read view of a setup register.
	function automatic logic [31:0] setup_view(nbs_pkg::nbs_setup_s s);
		logic [31:0] v;
		v = nbs_pkg::RST_WORD;
		v[nbs_pkg::POS_EN] = s.en;
		v[nbs_pkg::POS_SIZE +: 6] = s.size;
		v[nbs_pkg::POS_PREFETCHABLE_SELECT] = s.prefetchable_select;
		v[nbs_pkg::POS_WIDTH +: 2] = s.space ? 2'h0 : s.width;
		v[nbs_pkg::POS_SPACE] = s.space;
		return v;
	endfunction

	// Stored setup fields laid out as the register word, width not hidden.
	function automatic logic [31:0] setup_raw(nbs_pkg::nbs_setup_s s);
		logic [31:0] v;
		v = nbs_pkg::RST_WORD;
		v[nbs_pkg::POS_EN] = s.en;
		v[nbs_pkg::POS_SIZE +: 6] = s.size;
		v[nbs_pkg::POS_PREFETCHABLE_SELECT] = s.prefetchable_select;
		v[nbs_pkg::POS_WIDTH +: 2] = s.width;
		v[nbs_pkg::POS_SPACE] = s.space;
		return v;
	endfunction

	// Register word back into stored fields; the enable lives at bit 31, not next to the size.
	function automatic nbs_pkg::nbs_setup_s setup_load(logic [31:0] w);
		nbs_pkg::nbs_setup_s s;
		s.en = w[nbs_pkg::POS_EN];
		s.size = w[nbs_pkg::POS_SIZE +: 6];
		s.prefetchable_select = w[nbs_pkg::POS_PREFETCHABLE_SELECT];
		s.width = w[nbs_pkg::POS_WIDTH +: 2];
		s.space = w[nbs_pkg::POS_SPACE];
		return s;
	endfunction

	// Read view of a lower BAR word; a disabled BAR reads as zero.
	function automatic logic [31:0] bar_view(nbs_pkg::nbs_setup_s s, logic [31:0] base,
		logic [31:0] m);
		logic [31:0] v;
		v = base & m;
		v[nbs_pkg::POS_PREFETCHABLE_SELECT] = s.prefetchable_select;
		v[nbs_pkg::POS_WIDTH +: 2] = s.space ? 2'h0 : s.width;
		v[nbs_pkg::POS_SPACE] = s.space;
		return s.en ? v : nbs_pkg::RST_WORD;
	endfunction

	// Byte-lane merge of a write restricted to writable bits.
	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] wd,
		logic [3:0] be, logic [31:0] wm);
		logic [31:0] m;
		m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & wm;
		return (old & ~m) | (wd & m);
	endfunction

	function automatic logic [31:0] setup_wmask(logic width_rw);
		logic [31:0] m;
		m = nbs_pkg::RST_WORD;
		m[nbs_pkg::POS_EN] = 1'b1;
		m[nbs_pkg::POS_SIZE +: 6] = 6'h3f;
		m[nbs_pkg::POS_PREFETCHABLE_SELECT] = 1'b1;
		m[nbs_pkg::POS_WIDTH +: 2] = {2{width_rw}};
		m[nbs_pkg::POS_SPACE] = 1'b1;
		return m;
	endfunction

	always_comb begin
		setup4.en = en4_q;
		setup4.size = nbs_pkg::SIZE_BAR4;
		setup4.prefetchable_select = 1'b0;
		setup4.width = nbs_pkg::WIDTH_NARROW;
		setup4.space = nbs_pkg::SPACE_MEM;
		wide2 = (setup2_q.space == nbs_pkg::SPACE_MEM) &&
			(setup2_q.width == nbs_pkg::WIDTH_WIDE);
		size2 = eff_size(setup2_q, wide2);
		size3 = eff_size(setup3_q, 1'b0);
		mask2 = addr_mask(size2);
		mask3 = addr_mask(size3);
		mask4 = addr_mask(nbs_pkg::SIZE_BAR4);
		ok2 = bar_ok(setup2_q.en, size2);
		ok3 = !wide2 && bar_ok(setup3_q.en, size3);
		ok4 = bar_ok(en4_q, nbs_pkg::SIZE_BAR4);
		wmask2 = setup2_q.en ? mask2[31:0] : nbs_pkg::RST_WORD;
		if (wide2) begin
			wmask3 = setup2_q.en ? mask2[63:32] : nbs_pkg::RST_WORD;
		end else begin
			wmask3 = setup3_q.en ? mask3[31:0] : nbs_pkg::RST_WORD;
		end
		wmask4 = en4_q ? mask4[31:0] : nbs_pkg::RST_WORD;
	end

	always_comb begin
		wr_setup2 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_SETUP2;
		wr_setup3 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_SETUP3;
		wr_setup4 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_SETUP4;
		wr_tbase2 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_TBASE2;
		wr_tbase3 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_TBASE3;
		wr_bar2 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_BAR2;
		wr_bar3 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_BAR3;
		wr_bar4 = cfg_req.wr && cfg_req.addr == nbs_pkg::OFS_BAR4;
	end

	// Settings are cleared only at power-on, so hot and fundamental resets keep them.
	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			setup2_q <= nbs_pkg::RST_SETUP;
			setup3_q <= nbs_pkg::RST_SETUP;
			en4_q <= 1'b0;
		end else begin
			if (wr_setup2) begin
				setup2_q <= setup_load(merge(setup_raw(setup2_q), cfg_req.wdata, cfg_req.be,
					setup_wmask(1'b1)));
			end
			if (wr_setup3 && !wide2) begin
				setup3_q <= setup_load(merge(setup_raw(setup3_q), cfg_req.wdata, cfg_req.be,
					setup_wmask(1'b0)));
			end
			if (wr_setup4 && cfg_req.be[3]) begin
				en4_q <= cfg_req.wdata[nbs_pkg::POS_EN];
			end
		end
	end

	always_ff @(posedge clk or negedge por_n) begin
		if (!por_n) begin
			tbase2_q <= nbs_pkg::RST_WORD;
			tbase3_q <= nbs_pkg::RST_WORD;
		end else begin
			if (wr_tbase2) begin
				tbase2_q <= merge(tbase2_q, cfg_req.wdata, cfg_req.be, nbs_pkg::TBASE_LO_MASK);
			end
			if (wr_tbase3) begin
				// Low nibble is stored always; it only reads back in wide mode.
				tbase3_q <= merge(tbase3_q, cfg_req.wdata, cfg_req.be, 32'hffff_ffff);
			end
		end
	end

	// BAR base addresses belong to the enumerating host and follow the normal reset.
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			base2_q <= nbs_pkg::RST_WORD;
			base3_q <= nbs_pkg::RST_WORD;
			base4_q <= nbs_pkg::RST_WORD;
		end else begin
			if (wr_bar2) begin
				base2_q <= merge(base2_q, cfg_req.wdata, cfg_req.be, wmask2);
			end
			if (wr_bar3) begin
				base3_q <= merge(base3_q, cfg_req.wdata, cfg_req.be, wmask3);
			end
			if (wr_bar4) begin
				base4_q <= merge(base4_q, cfg_req.wdata, cfg_req.be, wmask4);
			end
		end
	end

	always_comb begin
		if (cfg_req.addr == nbs_pkg::OFS_BAR2) begin
			rdata_d = bar_view(setup2_q, base2_q, mask2[31:0]);
		end else if (cfg_req.addr == nbs_pkg::OFS_BAR3) begin
			if (wide2) begin
				rdata_d = setup2_q.en ? (base3_q & mask2[63:32]) : nbs_pkg::RST_WORD;
			end else begin
				rdata_d = bar_view(setup3_q, base3_q, mask3[31:0]);
			end
		end else if (cfg_req.addr == nbs_pkg::OFS_BAR4) begin
			rdata_d = bar_view(setup4, base4_q, mask4[31:0]);
		end else if (cfg_req.addr == nbs_pkg::OFS_SETUP2) begin
			rdata_d = setup_view(setup2_q);
		end else if (cfg_req.addr == nbs_pkg::OFS_TBASE2) begin
			rdata_d = tbase2_q & nbs_pkg::TBASE_LO_MASK;
		end else if (cfg_req.addr == nbs_pkg::OFS_SETUP3) begin
			rdata_d = wide2 ? nbs_pkg::RST_WORD : setup_view(setup3_q);
		end else if (cfg_req.addr == nbs_pkg::OFS_TBASE3) begin
			rdata_d = wide2 ? tbase3_q : (tbase3_q & nbs_pkg::TBASE_LO_MASK);
		end else if (cfg_req.addr == nbs_pkg::OFS_SETUP4) begin
			rdata_d = setup_view(setup4);
		end else begin
			rdata_d = nbs_pkg::RST_WORD;
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_rvalid <= 1'b0;
			cfg_rdata <= nbs_pkg::RST_WORD;
		end else begin
			cfg_rvalid <= cfg_req.rd;
			if (cfg_req.rd) begin
				cfg_rdata <= rdata_d;
			end
		end
	end

	// Narrow apertures compare the upper word against zero and translate it to zero.
	always_comb begin
		base2_full = {wide2 ? base3_q : 32'h0, base2_q};
		tbase2_full = {wide2 ? tbase3_q : 32'h0,
			tbase2_q & nbs_pkg::TBASE_LO_MASK};
	end

	nbs_xlat u_xlat2 (
		.ok(ok2),
		.space(setup2_q.space),
		.base(base2_full),
		.tbase(tbase2_full),
		.mask(wide2 ? mask2 : {32'hffff_ffff, mask2[31:0]}),
		.addr(xreq.addr),
		.io(xreq.io),
		.hit(hit[0]),
		.xaddr(xaddr2)
	);

	nbs_xlat u_xlat3 (
		.ok(ok3),
		.space(setup3_q.space),
		.base({32'h0, base3_q}),
		.tbase({32'h0, tbase3_q & nbs_pkg::TBASE_LO_MASK}),
		.mask({32'hffff_ffff, mask3[31:0]}),
		.addr(xreq.addr),
		.io(xreq.io),
		.hit(hit[1]),
		.xaddr(xaddr3)
	);

	// BAR4 has no translated-base register here, so its window passes untranslated.
	nbs_xlat u_xlat4 (
		.ok(ok4),
		.space(nbs_pkg::SPACE_MEM),
		.base({32'h0, base4_q}),
		.tbase({32'h0, base4_q}),
		.mask({32'hffff_ffff, mask4[31:0]}),
		.addr(xreq.addr),
		.io(xreq.io),
		.hit(hit[2]),
		.xaddr(xaddr4)
	);

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			xrsp <= '0;
		end else begin
			xrsp.valid <= xreq.valid;
			if (xreq.valid) begin
				xrsp.hit <= hit;
				if (hit[0]) begin
					xrsp.addr <= xaddr2;
				end else if (hit[1]) begin
					xrsp.addr <= xaddr3;
				end else if (hit[2]) begin
					xrsp.addr <= xaddr4;
				end else begin
					xrsp.addr <= xreq.addr;
				end
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			bar_live <= 3'h0;
		end else begin
			bar_live <= {ok4, ok3, ok2};
		end
	end
endmodule

// >>> dv/nbs_bar_regs_asserts.sv
module nbs_chk (
	input wire logic clk, // clock
	input wire logic arst_n, // hot reset
	input wire logic por_n, // power-on reset
	input nbs_pkg::nbs_cfg_req_s cfg_req, // configuration access
	input wire logic cfg_rvalid, // read answer strobe
	input wire logic [31:0] cfg_rdata, // read answer data
	input nbs_pkg::nbs_xreq_s xreq, // translation request
	input nbs_pkg::nbs_xrsp_s xrsp, // translation answer
	input wire logic [2:0] bar_live // decoding BARs
);
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	logic [11:0] ra;
	assign ra = cfg_req.addr;
	a_read_answers: assert property (cfg_req.rd |=> cfg_rvalid)
		else $error("read not answered");
	a_answer_has_read: assert property (cfg_rvalid |-> $past(cfg_req.rd))
		else $error("stray answer");
	a_xlat_answers: assert property (xreq.valid |=> xrsp.valid)
		else $error("no translation answer");
	a_xlat_no_stray: assert property (xrsp.valid |-> $past(xreq.valid))
		else $error("stray translation answer");
	a_setup_rsvd_zero: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_SETUP2 |-> cfg_rdata[30:10] == 21'h0)
		else $error("setup reserved bits set");
	a_io_width_zero: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_SETUP2 && cfg_rdata[0] |-> cfg_rdata[2:1] == 2'h0)
		else $error("width shown with io");
	a_setup3_narrow: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_SETUP3
		|-> cfg_rdata[30:10] == 21'h0 && cfg_rdata[2:1] == 2'h0)
		else $error("second setup width or reserved bits set");
	a_setup4_fixed: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_SETUP4 |-> cfg_rdata[30:0] == 31'h0000_00c0)
		else $error("fixed setup changed");
	a_tbase_nib_zero: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_TBASE2 |-> cfg_rdata[3:0] == 4'h0)
		else $error("tbase low bits set");
	a_bar4_low_zero: assert property (
		cfg_rvalid && $past(ra) == nbs_pkg::OFS_BAR4 |-> cfg_rdata[11:0] == 12'h0)
		else $error("small BAR bits set");
endmodule

bind nbs_bar_regs nbs_chk nbs_chk_inst (.clk(clk), .arst_n(arst_n), .por_n(por_n),
	.cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .xreq(xreq),
	.xrsp(xrsp), .bar_live(bar_live));

// >>> dv/nbs_host.sv
module nbs_host (
	input wire logic clk, // clock
	output nbs_pkg::nbs_cfg_req_s cfg_req, // configuration access
	input wire logic cfg_rvalid, // read answer strobe
	input wire logic [31:0] cfg_rdata // read answer data
);
	timeunit 1ns;
	timeprecision 1ns;
	initial cfg_req = '0;
	// Sizes outside the legal range are written too; the testbench checks how the BARs handle them.
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		#1 cfg_req = '{wr: 1'b1, rd: 1'b0, addr: a, be: 4'hf, wdata: d};
		@(posedge clk);
		#1 cfg_req = '{wr: 1'b0, rd: 1'b0, addr: a, be: 4'h0, wdata: ~d};
	endtask
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		@(posedge clk);
		#1 cfg_req = '{wr: 1'b0, rd: 1'b1, addr: a, be: 4'h0, wdata: 32'h0};
		@(posedge clk);
		#1 cfg_req.rd = 1'b0;
		d = (cfg_rvalid === 1'b1) ? cfg_rdata : 32'hxxxx_xxxx;
	endtask
endmodule

// >>> dv/testbench.sv
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk, arst_n, por_n, cfg_rvalid;
	logic [31:0] cfg_rdata;
	logic [2:0] bar_live;
	nbs_pkg::nbs_cfg_req_s cfg_req;
	nbs_pkg::nbs_xreq_s xreq;
	nbs_pkg::nbs_xrsp_s xrsp;
	int err_count = 0;
	int n_checks = 0;
	nbs_bar_regs nbs_bar_regs_inst (.clk(clk), .arst_n(arst_n), .por_n(por_n),
		.cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .xreq(xreq),
		.xrsp(xrsp), .bar_live(bar_live));
	nbs_host nbs_host_inst (.clk(clk), .cfg_req(cfg_req), .cfg_rvalid(cfg_rvalid),
		.cfg_rdata(cfg_rdata));
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input string s, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			err_count++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask
	task automatic rc(input string s, input logic [11:0] a, input logic [31:0] e);
		logic [31:0] d;
		nbs_host_inst.rd(a, d);
		chk(s, e, d);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		nbs_host_inst.wr(a, d);
	endtask
	task automatic xl(input logic [63:0] a);
		@(posedge clk);
		#1 xreq = '{valid: 1'b1, io: 1'b0, addr: a};
		@(posedge clk);
		#1 xreq.valid = 1'b0;
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	initial begin
		#2_000_000;
		err_count++;
		close_out();
	end
	initial begin
		arst_n = 1'b0;
		por_n = 1'b0;
		xreq = '0;
		repeat (5) @(posedge clk);
		#1 arst_n = 1'b1;
		por_n = 1'b1;
		rc("setup2", nbs_pkg::OFS_SETUP2, 32'h0000_0000);
		rc("tbase3", nbs_pkg::OFS_TBASE3, 32'h0000_0000);
		rc("setup4", nbs_pkg::OFS_SETUP4, 32'h0000_00c0);
		rc("bar4 off", nbs_pkg::OFS_BAR4, 32'h0000_0000);
		wr(12'h0a0, 32'hffff_ffff);
		rc("unmapped", 12'h0a0, 32'h0000_0000);
		$display("test reset done");
		wr(nbs_pkg::OFS_SETUP2, 32'hffff_ffff);
		rc("setup2 io", nbs_pkg::OFS_SETUP2, 32'h8000_03f9);
		wr(nbs_pkg::OFS_SETUP2, 32'h8000_0078);
		rc("setup2 mem", nbs_pkg::OFS_SETUP2, 32'h8000_0078);
		wr(nbs_pkg::OFS_BAR2, 32'hffff_ffff);
		rc("bar2 size7", nbs_pkg::OFS_BAR2, 32'hffff_ff88);
		wr(nbs_pkg::OFS_SETUP2, 32'h8000_0030);
		rc("bar2 size3", nbs_pkg::OFS_BAR2, 32'h0000_0000);
		wr(nbs_pkg::OFS_SETUP2, 32'h8000_0280);
		wr(nbs_pkg::OFS_BAR2, 32'hffff_ffff);
		rc("bar2 size40", nbs_pkg::OFS_BAR2, 32'h0000_0000);
		wr(nbs_pkg::OFS_SETUP2, 32'h0000_0070);
		rc("bar2 off", nbs_pkg::OFS_BAR2, 32'h0000_0000);
		$display("test narrow done");
		wr(nbs_pkg::OFS_SETUP2, 32'h8000_0144);
		wr(nbs_pkg::OFS_SETUP3, 32'hffff_ffff);
		rc("setup3 wide", nbs_pkg::OFS_SETUP3, 32'h0000_0000);
		wr(nbs_pkg::OFS_BAR2, 32'hffff_ffff);
		rc("bar2 wide", nbs_pkg::OFS_BAR2, 32'hfff0_0004);
		wr(nbs_pkg::OFS_BAR3, 32'hffff_ffff);
		rc("bar3 upper", nbs_pkg::OFS_BAR3, 32'hffff_ffff);
		wr(nbs_pkg::OFS_TBASE2, 32'h1230_000f);
		rc("tbase2", nbs_pkg::OFS_TBASE2, 32'h1230_0000);
		wr(nbs_pkg::OFS_TBASE3, 32'h0000_00ab);
		rc("tbase3", nbs_pkg::OFS_TBASE3, 32'h0000_00ab);
		xl(64'hffff_ffff_fff1_2345);
		chk("xlat hit", 32'h0000_0009, {28'h0, xrsp.valid, xrsp.hit});
		chk("xlat hi", 32'h0000_00ab, xrsp.addr[63:32]);
		chk("xlat lo", 32'h1231_2345, xrsp.addr[31:0]);
		chk("live wide", 32'h0000_0001, {29'h0, bar_live});
		$display("test wide done");
		wr(nbs_pkg::OFS_SETUP2, 32'h8000_0070);
		wr(nbs_pkg::OFS_SETUP3, 32'h8000_00c6);
		rc("setup3 width", nbs_pkg::OFS_SETUP3, 32'h8000_00c0);
		wr(nbs_pkg::OFS_SETUP4, 32'hffff_ffff);
		rc("setup4 en", nbs_pkg::OFS_SETUP4, 32'h8000_00c0);
		wr(nbs_pkg::OFS_BAR4, 32'hffff_ffff);
		rc("bar4 4k", nbs_pkg::OFS_BAR4, 32'hffff_f000);
		wr(nbs_pkg::OFS_BAR3, 32'h1234_5fff);
		rc("bar3 narrow", nbs_pkg::OFS_BAR3, 32'h1234_5000);
		wr(nbs_pkg::OFS_TBASE3, 32'habcd_e00f);
		rc("tbase3 narrow", nbs_pkg::OFS_TBASE3, 32'habcd_e000);
		xl(64'h0000_0000_1234_5678);
		chk("xlat3 hit", 32'h0000_000a, {28'h0, xrsp.valid, xrsp.hit});
		chk("xlat3 lo", 32'habcd_e678, xrsp.addr[31:0]);
		chk("xlat3 hi", 32'h0000_0000, xrsp.addr[63:32]);
		chk("live all", 32'h0000_0007, {29'h0, bar_live});
		@(posedge clk);
		#1 arst_n = 1'b0;
		@(posedge clk);
		#1 arst_n = 1'b1;
		rc("setup4 kept", nbs_pkg::OFS_SETUP4, 32'h8000_00c0);
		rc("setup2 kept", nbs_pkg::OFS_SETUP2, 32'h8000_0070);
		rc("bar4 cleared", nbs_pkg::OFS_BAR4, 32'h0000_0000);
		$display("test fixed and reset done");
		close_out();
	end
endmodule
